// ### hdl/burst_sram_controller.sv
/*
  controller end: makes the clock pair, issues one read or write burst
  per k beat from a user request, returns read words one by one.
  assumes the memory end shares i_clock and the burst_link_if.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_sram_controller
  import burst_sram_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_wr_valid,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [BURST_LEN*DATA_W-1:0] i_wr_data,
  input wire logic [BURST_LEN*LANES-1:0] i_wr_lane_sel_n,
  output logic o_wr_ready,
  input wire logic i_rd_valid,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic o_rd_ready,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_rd_data_valid,
  burst_link_if.controller link
);

  // --------------------------------------------------------------------
  // clock pair and request capture
  // --------------------------------------------------------------------
  logic k_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [ADDR_W-1:0] rd_addr_r;
  logic [BURST_LEN*DATA_W-1:0] wbuf_r;
  logic [BURST_LEN*LANES-1:0] wsel_r;
  logic wsel_n_r;
  logic rsel_n_r;
  logic [ADDR_W-1:0] addr_r;
  logic [2:0] wleft_r;
  logic [2:0] rleft_r;
  logic [DATA_W-1:0] wdata_r;
  logic [LANES-1:0] lanes_n_r;
  logic [DATA_W-1:0] rd_data_r;
  logic rd_valid_r;
  wire logic issue_slot;
  wire logic issue_rd;
  wire logic issue_wr;
  wire logic wr_take;
  wire logic rd_take;
  wire logic [WORD_IDX_W-1:0] wword;

  // next cycle is a k beat; a new read or write needs its port's last burst count (rleft_r or wleft_r) at 2 or less
  assign issue_slot = !k_r;
  assign issue_rd = issue_slot && rd_pend_r && rsel_n_r
    && (rleft_r <= 3'h2);
  assign issue_wr = issue_slot && wr_pend_r && !issue_rd
    && (wleft_r <= 3'h2) && wsel_n_r;
  assign wr_take = i_wr_valid && !wr_pend_r;
  assign rd_take = i_rd_valid && !rd_pend_r;
  assign wword = WORD_IDX_W'(BURST_START - wleft_r);

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      k_r <= 1'b0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= '0;
      rd_addr_r <= '0;
      wbuf_r <= '0;
      wsel_r <= '1;
    end else begin
      k_r <= !k_r;
      wr_pend_r <= wr_take || (wr_pend_r && !issue_wr);
      rd_pend_r <= rd_take || (rd_pend_r && !issue_rd);
      if (wr_take) begin
        wr_addr_r <= i_wr_addr;
        wbuf_r <= i_wr_data;
        wsel_r <= i_wr_lane_sel_n;
      end
      if (rd_take) begin
        rd_addr_r <= i_rd_addr;
      end
    end
  end

  // --------------------------------------------------------------------
  // pin drive
  // --------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wsel_n_r <= 1'b1;
      rsel_n_r <= 1'b1;
      addr_r <= '0;
      wleft_r <= 3'h0;
      rleft_r <= 3'h0;
      wdata_r <= '0;
      lanes_n_r <= '1;
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      wsel_n_r <= !issue_wr;
      rsel_n_r <= !issue_rd;
      if (issue_wr) begin
        addr_r <= wr_addr_r;
      end else if (issue_rd) begin
        addr_r <= rd_addr_r;
      end
      if (!wsel_n_r) begin
        wleft_r <= BURST_START;
      end else if (wleft_r != 3'h0) begin
        wleft_r <= wleft_r - 3'h1;
      end
      if (!rsel_n_r) begin
        rleft_r <= BURST_START;
      end else if (rleft_r != 3'h0) begin
        rleft_r <= rleft_r - 3'h1;
      end
      if (!wsel_n_r || wleft_r > 3'h1) begin
        wdata_r <= wbuf_r[(!wsel_n_r ? 0 : wword + 1)*DATA_W +: DATA_W];
        lanes_n_r <= wsel_r[(!wsel_n_r ? 0 : wword + 1)*LANES +: LANES];
      end else begin
        lanes_n_r <= '1;
      end
      rd_valid_r <= link.read_data_valid;
      rd_data_r <= link.rdata;
    end
  end

  assign link.k = k_r;
  assign link.k_n = !k_r;
  assign link.write_port_select_n = wsel_n_r;
  assign link.read_port_select_n = rsel_n_r;
  assign link.addr = addr_r;
  assign link.wdata = wdata_r;
  assign link.byte_lane_write_select_n = lanes_n_r;
  assign o_wr_ready = !wr_pend_r;
  assign o_rd_ready = !rd_pend_r;
  assign o_rd_data = rd_data_r;
  assign o_rd_data_valid = rd_valid_r;

endmodule
`default_nettype wire

// ### hdl/burst_sram_pkg.sv
/*
  shared constants for the split-port burst sram link: widths, lanes,
  burst length and storage depth.
  assumes both ends and the bench import it whole.
*/
package burst_sram_pkg;
  // --------------------------------------------------------------------
  // variant and widths
  // --------------------------------------------------------------------
  localparam bit WIDE_VARIANT = 1'b1;
  localparam int NARROW_DATA_W = 18;
  localparam int WIDE_DATA_W = 36;
  localparam int NARROW_ADDR_W = 21;
  localparam int WIDE_ADDR_W = 20;
  localparam int DATA_W = WIDE_VARIANT ? WIDE_DATA_W : NARROW_DATA_W;
  localparam int ADDR_W = WIDE_VARIANT ? WIDE_ADDR_W : NARROW_ADDR_W;
  localparam int LANE_W = 9;
  localparam int LANES = DATA_W / LANE_W;
  // --------------------------------------------------------------------
  // burst and storage
  // --------------------------------------------------------------------
  localparam int BURST_LEN = 4;
  localparam int WORD_IDX_W = 2;
  localparam logic [2:0] BURST_START = 3'h4;
  localparam int STORE_LOC_W = 4;
  localparam int STORE_IDX_W = STORE_LOC_W + WORD_IDX_W;
  localparam int STORE_WORDS = 1 << STORE_IDX_W;
endpackage

// ### hdl/burst_link_if.sv
/*
  pin bundle between the memory controller and the burst sram.
  assumes one shared clock; k marks the positive-clock beat, k_n the other.
*/
`timescale 1ns/1ps
`default_nettype none
interface burst_link_if
  import burst_sram_pkg::*;
();
  logic k;
  logic k_n;
  logic write_port_select_n;
  logic read_port_select_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [LANES-1:0] byte_lane_write_select_n;
  logic [DATA_W-1:0] rdata;
  logic rdata_oe;
  logic read_data_valid;
  logic echo_clock;
  logic echo_clock_n;
  modport memory (
    input k, k_n, write_port_select_n, read_port_select_n, addr, wdata,
    input byte_lane_write_select_n,
    output rdata, rdata_oe, read_data_valid, echo_clock, echo_clock_n
  );
  modport controller (
    output k, k_n, write_port_select_n, read_port_select_n, addr, wdata,
    output byte_lane_write_select_n,
    input rdata, rdata_oe, read_data_valid, echo_clock, echo_clock_n
  );
endinterface
`default_nettype wire

// ### hdl/burst_sram_memory.sv
/*
  memory end of the split-port burst sram: write port, read port,
  shared address capture, lane masking, echo clock and valid flag.
  assumes the controller makes k on the same i_clock, one beat per cycle.
*/
// What this block does
// - write data sampled on both clock beats
// - write select low at k starts write
// - deselected write port ignores data inputs
// - unselected byte lanes stay unchanged
// - each select governs one nine-bit lane
// - lane selects sampled with their data beat
// - address captured at k only when requested
// - one address bus shared by both ports
// - address width 20 wide, 21 narrow
// - address ignored when matching port deselected
// - read data launched on both clock beats
// - read select low at k starts read
// - finish burst, then float read outputs
// - every read gives four sequential words
// - valid flag aligned with echo clock
// - accesses begin only at k rising
// - echo clock toggles following k
`timescale 1ns/1ps
`default_nettype none
module burst_sram_memory
  import burst_sram_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  burst_link_if.memory link
);

  // --------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------
  logic [DATA_W-1:0] store_r [STORE_WORDS];

  // --------------------------------------------------------------------
  // request decode
  // --------------------------------------------------------------------
  logic [2:0] wr_left_r;
  logic [2:0] wr_left_nxt;
  logic [2:0] rd_left_r;
  logic [2:0] rd_left_nxt;
  logic [STORE_LOC_W-1:0] wr_loc_r;
  logic [STORE_LOC_W-1:0] wr_loc_nxt;
  logic [STORE_LOC_W-1:0] rd_loc_r;
  logic [STORE_LOC_W-1:0] rd_loc_nxt;
  wire logic k_beat;
  wire logic wr_start;
  wire logic rd_start;
  wire logic wr_active;
  wire logic rd_active;
  wire logic [STORE_LOC_W-1:0] addr_loc;

  assign k_beat = link.k;
  assign addr_loc = link.addr[STORE_LOC_W-1:0];
  assign wr_active = wr_left_r != 3'h0;
  assign rd_active = rd_left_r != 3'h0;
  assign wr_start = k_beat && !link.write_port_select_n
    && (wr_left_r <= 3'h1);
  assign rd_start = k_beat && !link.read_port_select_n
    && (rd_left_r <= 3'h1);

  assign wr_left_nxt = wr_start ? BURST_START :
    (wr_active ? wr_left_r - 3'h1 : 3'h0);
  assign rd_left_nxt = rd_start ? BURST_START :
    (rd_active ? rd_left_r - 3'h1 : 3'h0);
  assign wr_loc_nxt = wr_start ? addr_loc : wr_loc_r;
  assign rd_loc_nxt = rd_start ? addr_loc : rd_loc_r;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_left_r <= 3'h0;
      rd_left_r <= 3'h0;
      wr_loc_r <= '0;
      rd_loc_r <= '0;
    end else begin
      wr_left_r <= wr_left_nxt;
      rd_left_r <= rd_left_nxt;
      wr_loc_r <= wr_loc_nxt;
      rd_loc_r <= rd_loc_nxt;
    end
  end

  // --------------------------------------------------------------------
  // write port
  // --------------------------------------------------------------------
  wire logic [WORD_IDX_W-1:0] wr_word;
  wire logic [STORE_IDX_W-1:0] wr_idx;
  wire logic [LANES-1:0] lane_we;

  assign wr_word = WORD_IDX_W'(BURST_START - wr_left_r);
  assign wr_idx = {wr_loc_r, wr_word};

  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane++) begin : g_lane
      assign lane_we[lane] = wr_active
        && !link.byte_lane_write_select_n[lane];
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    for (int j = 0; j < LANES; j++) begin
      if (lane_we[j]) begin
        store_r[wr_idx][j*LANE_W +: LANE_W] <=
          link.wdata[j*LANE_W +: LANE_W];
      end
    end
  end

  // --------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic rdata_oe_r;
  logic valid_r;
  logic echo_r;
  wire logic [WORD_IDX_W-1:0] rd_word;
  wire logic [STORE_IDX_W-1:0] rd_idx;
  wire logic wr_hit;

  assign rd_word = WORD_IDX_W'(BURST_START - rd_left_r);
  assign rd_idx = {rd_loc_r, rd_word};
  assign wr_hit = wr_active && (wr_idx == rd_idx);

  // newest data wins when a read meets a write in flight
  always_comb begin
    rdata_nxt = store_r[rd_idx];
    for (int i = 0; i < LANES; i++) begin
      if (wr_hit && lane_we[i]) begin
        rdata_nxt[i*LANE_W +: LANE_W] = link.wdata[i*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_r <= '0;
      rdata_oe_r <= 1'b0;
      valid_r <= 1'b0;
      echo_r <= 1'b0;
    end else begin
      rdata_r <= rd_active ? rdata_nxt : rdata_r;
      rdata_oe_r <= rd_active;
      valid_r <= rd_active;
      echo_r <= link.k;
    end
  end

  // --------------------------------------------------------------------
  // pins
  // --------------------------------------------------------------------
  assign link.rdata = rdata_r;
  assign link.rdata_oe = rdata_oe_r;
  assign link.read_data_valid = valid_r;
  assign link.echo_clock = echo_r;
  assign link.echo_clock_n = !echo_r;

endmodule
`default_nettype wire

// ### verification/burst_link_monitor.sv
/*
  checker on the burst link pins between controller and memory.
  assumes one clock; placed beside the interface in tb.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_link_monitor
  import burst_sram_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic k,
  input wire logic k_n,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [LANES-1:0] byte_lane_write_select_n,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic rdata_oe,
  input wire logic read_data_valid,
  input wire logic echo_clock,
  input wire logic echo_clock_n
);
  // ------------------------------------------------------------
  // pin assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  a_echo_follows_k: assert property (1 |=> echo_clock == $past(k))
    else $error("echo clock not k delayed");
  a_k_toggles: assert property (1 |=> k != $past(k))
    else $error("k stopped toggling");
  a_pairs_inverse: assert property (k_n == !k && echo_clock_n == !echo_clock)
    else $error("clock pair not inverse");
  a_wsel_on_k: assert property (!write_port_select_n |-> k)
    else $error("write select off k beat");
  a_rsel_on_k: assert property (!read_port_select_n |-> k)
    else $error("read select off k beat");
  a_read_four_words: assert property (
    !read_port_select_n |-> ##2 read_data_valid [*4])
    else $error("read burst not four words");
  a_valid_with_oe: assert property (read_data_valid |-> rdata_oe)
    else $error("valid without drive");
  a_float_after: assert property ($fell(read_data_valid) |-> !rdata_oe)
    else $error("read outputs not floated");
  a_valid_echo_edge: assert property (
    $changed(read_data_valid) |-> $changed(echo_clock))
    else $error("valid not echo aligned");
  a_write_gap: assert property (
    !write_port_select_n |=> write_port_select_n [*3])
    else $error("write select inside burst");
  c_write: cover property (!write_port_select_n);
  c_read: cover property (!read_port_select_n);
  c_valid: cover property ($rose(read_data_valid));
endmodule
`default_nettype wire

// ### verification/tb.sv
/*
  testbench: controller and memory joined by burst_link_if.
  assumes one 50 MHz clock and an async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import burst_sram_pkg::*;
;
  localparam int WL = BURST_LEN*DATA_W;
  localparam int LL = BURST_LEN*LANES;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_wr_valid = 1'b0;
  logic i_rd_valid = 1'b0;
  logic [ADDR_W-1:0] i_wr_addr = '0;
  logic [ADDR_W-1:0] i_rd_addr = '0;
  logic [WL-1:0] i_wr_data = '0;
  logic [LL-1:0] i_wr_lane_sel_n = '1;
  logic o_wr_ready;
  logic o_rd_ready;
  logic o_rd_data_valid;
  logic [DATA_W-1:0] o_rd_data;
  logic [WL-1:0] shadow;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  burst_link_if link ();
  burst_sram_controller burst_sram_controller_inst (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_wr_valid(i_wr_valid),
    .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
    .i_wr_lane_sel_n(i_wr_lane_sel_n), .o_wr_ready(o_wr_ready),
    .i_rd_valid(i_rd_valid), .i_rd_addr(i_rd_addr),
    .o_rd_ready(o_rd_ready), .o_rd_data(o_rd_data),
    .o_rd_data_valid(o_rd_data_valid), .link(link.controller));
  burst_sram_memory burst_sram_memory_inst (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .link(link.memory));
  burst_link_monitor burst_link_monitor_inst (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .k(link.k),
    .k_n(link.k_n), .write_port_select_n(link.write_port_select_n),
    .read_port_select_n(link.read_port_select_n), .addr(link.addr),
    .wdata(link.wdata),
    .byte_lane_write_select_n(link.byte_lane_write_select_n),
    .rdata(link.rdata), .rdata_oe(link.rdata_oe),
    .read_data_valid(link.read_data_valid),
    .echo_clock(link.echo_clock), .echo_clock_n(link.echo_clock_n));
  always #10 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task wrap_up();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task go(input bit w, input bit r);
    int n;
    n = 0;
    while ((o_wr_ready !== 1'b1 || o_rd_ready !== 1'b1) && n < 50) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    i_wr_valid = w;
    i_rd_valid = r;
    @(posedge i_clock);
    #1;
    i_wr_valid = 1'b0;
    i_rd_valid = 1'b0;
  endtask
  task collect(input logic [WL-1:0] exp);
    int n;
    n = 0;
    repeat (20) begin
      @(posedge i_clock);
      #1;
      if (o_rd_data_valid === 1'b1) begin
        if (n < BURST_LEN) chk(o_rd_data, exp[n*DATA_W +: DATA_W]);
        n++;
      end
    end
    chk(DATA_W'(n), DATA_W'(BURST_LEN));
  endtask
  function automatic logic [WL-1:0] merge(input logic [WL-1:0] old,
      input logic [WL-1:0] nw, input logic [LL-1:0] sel_n);
    merge = old;
    for (int i = 0; i < LL; i++) begin
      if (!sel_n[i]) merge[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
    end
  endfunction
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task full_write_read();
    i_wr_addr = 20'h0_0002;
    i_rd_addr = 20'h0_0002;
    i_wr_data = {36'h4_4444_4444, 36'h3_3333_3333,
                 36'h2_2222_2222, 36'h1_1111_1111};
    i_wr_lane_sel_n = '0;
    go(1'b1, 1'b0);
    shadow = i_wr_data;
    go(1'b0, 1'b1);
    collect(shadow);
  endtask
  task lane_masks();
    i_wr_data = ~shadow;
    i_wr_lane_sel_n = 16'h0F5E;
    go(1'b1, 1'b0);
    shadow = merge(shadow, i_wr_data, i_wr_lane_sel_n);
    go(1'b0, 1'b1);
    collect(shadow);
  endtask
  task both_ports();
    i_wr_addr = 20'h0_0007;
    i_wr_data = {4{36'h0_5A5A_5A5A}};
    i_wr_lane_sel_n = '0;
    go(1'b1, 1'b1);
    collect(shadow);
    i_rd_addr = 20'h0_0007;
    go(1'b0, 1'b1);
    collect(i_wr_data);
  endtask
  initial begin
    repeat (8) @(posedge i_clock);
    #1;
    i_reset_n = 1'b1;
    full_write_read();
    lane_masks();
    both_ports();
    wrap_up();
  end
endmodule
`default_nettype wire
